/* File: hw/sw_pkg.sv */
package sw_pkg;
    localparam int NUM_OUT = 8;
    localparam int WORD_BITS = 16;
    localparam int MIN_FRAME_BITS = 16;
    localparam int FRAME_STEP_BITS = 8;
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int FILTER_MIN_US = 100;
    localparam int FILTER_MAX_US = 300;
    // least figure of the window, cycles per microsecond rounded down
    localparam int FILTER_CYCLES =
        (FILTER_MIN_US * (CLK_FREQ_HZ / 1_000_000));
    localparam logic [7:0] OUT_OFF_RST = 8'h00;
    localparam logic [7:0] DET_OFF_RST = 8'h00;
    localparam logic [7:0] STATUS_PAD = 8'h00;

    typedef struct packed {
        logic [7:0] detect_en;
        logic [7:0] out_on;
    } command_t;

    typedef struct packed {
        logic [7:0] pad;
        logic [7:0] fault;
    } status_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAME = 2'b01
    } link_state_t;
endpackage

/* File: hw/octal_switch_spi_fault_logic.sv */
`timescale 1ns/1ps
module octal_switch_spi_fault_logic
    import sw_pkg::*;
#(
    parameter int FILTER_COUNT = FILTER_CYCLES,
    parameter int FRAME_CNT_W = 8
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic logic_supply_ok_in,
    input wire logic battery_overvoltage_in,
    input wire logic battery_undervoltage_in,
    input wire logic logic_undervoltage_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic [7:0] open_load_cmp_in,
    input wire logic [7:0] short_fault_in,
    input wire logic [7:0] over_temp_in,
    output logic miso_out,
    output logic [7:0] drive_on_out,
    output logic [7:0] detect_current_out,
    output logic sleep_out
);
    // the counter must reach 16 and still see the step of 8
    if (FILTER_COUNT < 1 || FRAME_CNT_W < 5) begin : g_bad_params
        $error("bad parameters");
    end

    logic rst_a_ff, rst_b_ff;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    wire rst_n = rst_b_ff;

    // two-flop sync of all asynchronous inputs
    localparam int SW = 5 + 24;
    wire [SW-1:0] raw_in = {enable_in, logic_supply_ok_in,
        battery_overvoltage_in, battery_undervoltage_in,
        logic_undervoltage_in, open_load_cmp_in, short_fault_in, over_temp_in};
    logic [SW-1:0] s1_ff, s2_ff;
    logic [2:0] ps1_ff, ps2_ff;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            ps1_ff <= 3'b100;
            ps2_ff <= 3'b100;
        end else begin
            s1_ff <= raw_in;
            s2_ff <= s1_ff;
            ps1_ff <= {cs_n_in, sclk_in, mosi_in};
            ps2_ff <= ps1_ff;
        end
    end
    wire en_s = s2_ff[28];
    wire vdd_ok_s = s2_ff[27];
    wire ov_s = s2_ff[26];
    wire uv_s = s2_ff[25] | s2_ff[24];
    wire [7:0] olc_s = s2_ff[23:16];
    wire [7:0] sc_s = s2_ff[15:8];
    wire [7:0] ot_s = s2_ff[7:0];
    wire cs_s = ps2_ff[2];
    wire sclk_s = ps2_ff[1];
    wire mosi_s = ps2_ff[0];

    logic cs_d_ff, sclk_d_ff, uv_d_ff;
    wire sleep = !en_s || !vdd_ok_s;
    // under-voltage recovery acts as a fresh power-on
    wire soft_rst = sleep || uv_s;
    wire cs_fall = cs_d_ff && !cs_s;
    wire cs_rise = !cs_d_ff && cs_s;
    wire sclk_rise = !sclk_d_ff && sclk_s && !cs_s;
    wire sclk_fall = sclk_d_ff && !sclk_s && !cs_s;

    link_state_t state_ff;
    logic [15:0] rx_ff;
    logic [15:0] tx_ff;
    logic [FRAME_CNT_W-1:0] cnt_ff;
    command_t cmd_ff;
    logic [7:0] ol_latch_ff;
    logic [$clog2(FILTER_COUNT+1)-1:0] filt_ff;
    logic miso_ff;

    wire cnt_ok = (cnt_ff >= FRAME_CNT_W'(MIN_FRAME_BITS)) &&
        (cnt_ff[2:0] == 3'd0);
    wire filt_done = (filt_ff == '0);
    // open load counted only off, detection on, after filter
    wire [7:0] ol_now = olc_s & ~cmd_ff.out_on & cmd_ff.detect_en
        & {8{filt_done}};
    // short faults bypass detection enable
    wire [7:0] fault_now =
        ol_latch_ff | ol_now | sc_s | ot_s;
    status_t stat;
    assign stat.pad = STATUS_PAD;
    assign stat.fault = fault_now;
    // echo: after 16 bits the shift register feeds its own input out
    wire tx_in = rx_ff[15];

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cs_d_ff <= 1'b1;
            sclk_d_ff <= 1'b0;
            uv_d_ff <= 1'b0;
        end else begin
            cs_d_ff <= cs_s;
            sclk_d_ff <= sclk_s;
            uv_d_ff <= uv_s;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            rx_ff <= '0;
            tx_ff <= '0;
            cnt_ff <= '0;
            miso_ff <= 1'b0;
        end else if (cs_fall) begin
            state_ff <= ST_FRAME;
            tx_ff <= {stat[14:0], 1'b0};
            miso_ff <= stat[15];
            cnt_ff <= '0;
        end else if (state_ff == ST_FRAME && cs_rise) begin
            state_ff <= ST_IDLE;
        end else if (state_ff == ST_FRAME && sclk_rise) begin
            rx_ff <= {rx_ff[14:0], mosi_s};
            if (cnt_ff != '1) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end else if (state_ff == ST_FRAME && sclk_fall) begin
            miso_ff <= (cnt_ff >= FRAME_CNT_W'(WORD_BITS)) ?
                tx_in : tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b0};
        end
    end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ff <= {DET_OFF_RST, OUT_OFF_RST};
        end else if (soft_rst) begin
            cmd_ff <= {DET_OFF_RST, OUT_OFF_RST};
        end else if (state_ff == ST_FRAME && cs_rise && cnt_ok) begin
            // bits 0-7 drive, 8-15 detect currents
            cmd_ff <= rx_ff;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            filt_ff <= '0;
        end else if (state_ff == ST_FRAME && cs_rise) begin
            filt_ff <= $bits(filt_ff)'(FILTER_COUNT);
        end else if (!filt_done) begin
            filt_ff <= filt_ff - 1'b1;
        end
    end

    // a frame start is the read; new events that cycle still stick
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ol_latch_ff <= '0;
        end else if (soft_rst) begin
            ol_latch_ff <= '0;
        end else if (cs_fall) begin
            ol_latch_ff <= ol_now;
        end else begin
            ol_latch_ff <= ol_latch_ff | ol_now;
        end
    end

    // thermal shutdown per output; command kept so output retries
    wire [7:0] drive = cmd_ff.out_on & ~ot_s & {8{!ov_s}};

    logic [7:0] drive_ff, det_ff;
    logic sleep_ff;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            drive_ff <= '0;
            det_ff <= '0;
            sleep_ff <= 1'b1;
        end else begin
            drive_ff <= soft_rst ? 8'h00 : drive;
            det_ff <= soft_rst ? 8'h00 : cmd_ff.detect_en;
            sleep_ff <= sleep;
        end
    end
    assign drive_on_out = drive_ff;
    assign detect_current_out = det_ff;
    assign sleep_out = sleep_ff;
    assign miso_out = miso_ff;

    a_sleep_clears: assert property (@(posedge clock_in) disable iff (!rst_n)
        soft_rst |=> (cmd_ff == '0) ##1 (drive_on_out == 8'h00))
        else $error("sleep did not clear state");
    a_bad_frame_kept: assert property (@(posedge clock_in) disable iff (!rst_n)
        (state_ff == ST_FRAME && cs_rise && !cnt_ok && !soft_rst)
        |=> $stable(cmd_ff))
        else $error("bad frame changed command");
    a_good_frame_apply: assert property (@(posedge clock_in)
        disable iff (!rst_n)
        (state_ff == ST_FRAME && cs_rise && cnt_ok && !soft_rst)
        |=> cmd_ff == $past(rx_ff))
        else $error("command not applied");
    a_ov_all_off: assert property (@(posedge clock_in) disable iff (!rst_n)
        ov_s |=> drive_on_out == 8'h00)
        else $error("overvoltage left output on");
    a_ot_one_off: assert property (@(posedge clock_in) disable iff (!rst_n)
        (ot_s[0] && !soft_rst) |=> !drive_on_out[0])
        else $error("overtemp output stayed on");
    a_filter_masks: assert property (@(posedge clock_in) disable iff (!rst_n)
        !filt_done |-> ol_now == 8'h00)
        else $error("open load seen during filter");
    a_short_reported: assert property (@(posedge clock_in)
        disable iff (!rst_n)
        sc_s[0] |-> stat.fault[0] && stat.pad == 8'h00)
        else $error("short not reported");
    a_ol_latched: assert property (@(posedge clock_in) disable iff (!rst_n)
        (ol_now[0] && !soft_rst && !cs_fall) |=> ol_latch_ff[0])
        else $error("open load not latched");
    a_status_load: assert property (@(posedge clock_in) disable iff (!rst_n)
        cs_fall |=> miso_out == 1'b0)
        else $error("status pad bit not zero");
    a_det_follows: assert property (@(posedge clock_in) disable iff (!rst_n)
        1'b1 |=> detect_current_out == ($past(soft_rst) ? 8'h00 :
        $past(cmd_ff.detect_en)))
        else $error("detection current wrong");
    a_drive_follows: assert property (@(posedge clock_in) disable iff (!rst_n)
        1'b1 |=> drive_on_out == ($past(soft_rst) ? 8'h00 :
        $past(drive)))
        else $error("drive does not follow command");
    a_sleep_flag: assert property (@(posedge clock_in) disable iff (!rst_n)
        1'b1 |=> sleep_out == $past(sleep))
        else $error("sleep flag wrong");
    a_uv_all_off: assert property (@(posedge clock_in) disable iff (!rst_n)
        uv_s |=> drive_on_out == 8'h00)
        else $error("undervoltage left output on");
    a_count_clear: assert property (@(posedge clock_in) disable iff (!rst_n)
        cs_fall |=> cnt_ff == '0)
        else $error("frame count not cleared");
    a_filter_start: assert property (@(posedge clock_in) disable iff (!rst_n)
        (state_ff == ST_FRAME && cs_rise) |=> !filt_done)
        else $error("filter not started");
    a_frame_end: assert property (@(posedge clock_in) disable iff (!rst_n)
        (state_ff == ST_FRAME && cs_rise && !cs_fall)
        |=> state_ff == ST_IDLE)
        else $error("frame not closed");
    a_echo_bit: assert property (@(posedge clock_in) disable iff (!rst_n)
        (state_ff == ST_FRAME && sclk_fall && !cs_fall &&
        cnt_ff >= FRAME_CNT_W'(WORD_BITS))
        |=> miso_out == $past(rx_ff[15]))
        else $error("echo bit wrong");
    a_status_shift: assert property (@(posedge clock_in) disable iff (!rst_n)
        (state_ff == ST_FRAME && sclk_fall && !cs_fall &&
        cnt_ff < FRAME_CNT_W'(WORD_BITS))
        |=> miso_out == $past(tx_ff[15]))
        else $error("status bit wrong");
    a_latch_reset: assert property (@(posedge clock_in) disable iff (!rst_n)
        soft_rst |=> ol_latch_ff == 8'h00)
        else $error("open load latch kept in sleep");
    a_ol_only_off: assert property (@(posedge clock_in) disable iff (!rst_n)
        1'b1 |-> (ol_now & cmd_ff.out_on) == 8'h00)
        else $error("open load seen on driven output");
    a_pad_zero: assert property (@(posedge clock_in) disable iff (!rst_n)
        1'b1 |-> stat.pad == 8'h00)
        else $error("status pad not zero");
endmodule

/* File: test/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out,
    input wire logic miso_in
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end

    // mode 0; sample late in the high phase as the device lags a few clocks
    task automatic xfer(input int n, input logic [31:0] d,
                        output logic [31:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_out = d[i];
            #160 sclk_out = 1'b1;
            #150 rx = {rx[30:0], miso_in};
            #10 sclk_out = 1'b0;
        end
        #160 cs_n_out = 1'b1;
        // released line must not keep showing the last bit
        mosi_out = ~mosi_out;
        #300_100;
    endtask
endmodule

/* File: test/tb_octal_switch_spi_fault_logic.sv */
`timescale 1ns/1ps
module tb_octal_switch_spi_fault_logic;
    import sw_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in, enable_in, logic_supply_ok_in, battery_overvoltage_in;
    logic battery_undervoltage_in, logic_undervoltage_in;
    logic cs_n_in, sclk_in, mosi_in, miso_out, sleep_out;
    logic [7:0] open_load_cmp_in, short_fault_in, over_temp_in;
    logic [7:0] drive_on_out, detect_current_out;
    logic [31:0] rx;
    int miscompares = 0;
    int check_count = 0;

    always #20 clock_in = ~clock_in;

    octal_switch_spi_fault_logic #(
        .FILTER_COUNT(20)
    ) u_octal_switch_spi_fault_logic (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
        .logic_supply_ok_in(logic_supply_ok_in),
        .battery_overvoltage_in(battery_overvoltage_in),
        .battery_undervoltage_in(battery_undervoltage_in),
        .logic_undervoltage_in(logic_undervoltage_in),
        .cs_n_in(cs_n_in), .sclk_in(sclk_in), .mosi_in(mosi_in),
        .open_load_cmp_in(open_load_cmp_in), .short_fault_in(short_fault_in),
        .over_temp_in(over_temp_in), .miso_out(miso_out),
        .drive_on_out(drive_on_out), .detect_current_out(detect_current_out),
        .sleep_out(sleep_out));

    spi_master_model u_spi_master_model (.cs_n_out(cs_n_in),
        .sclk_out(sclk_in), .mosi_out(mosi_in), .miso_in(miso_out));

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_out(input logic [7:0] drv, input logic [7:0] det);
        check("drive", {24'h0, drv}, {24'h0, drive_on_out});
        check("detect", {24'h0, det}, {24'h0, detect_current_out});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic send(input int n, input logic [31:0] d);
        u_spi_master_model.xfer(n, d, rx);
        wait_cyc(1);
    endtask

    task automatic s_basic;
        send(16, 32'h0000_3ca5);
        check("status", 32'h0, {16'h0, rx[15:0]});
        check_out(8'ha5, 8'h3c);
    endtask

    task automatic s_count;
        send(20, 32'h000f_ffff);
        check_out(8'ha5, 8'h3c);
        send(24, 32'h0011_c35a);
        check_out(8'h5a, 8'hc3);
    endtask

    task automatic s_echo;
        send(32, 32'h1234_00ff);
        check("echo", 32'h1234, {16'h0, rx[15:0]});
        check("lead", 32'h0, {16'h0, rx[31:16]});
        check_out(8'hff, 8'h00);
    endtask

    task automatic s_faults;
        over_temp_in = 8'h08;
        wait_cyc(10);
        check_out(8'hf7, 8'h00);
        short_fault_in = 8'h20;
        send(16, 32'h0000_00ff);
        // bits 3 and 5 commanded on: one means short or heat
        check("status", 32'h0028, {16'h0, rx[15:0]});
        over_temp_in = 8'h00;
        short_fault_in = 8'h00;
        wait_cyc(10);
        check_out(8'hff, 8'h00);
        battery_overvoltage_in = 1'b1;
        wait_cyc(10);
        check_out(8'h00, 8'h00);
        battery_overvoltage_in = 1'b0;
        wait_cyc(10);
        check_out(8'hff, 8'h00);
    endtask

    task automatic s_open;
        send(16, 32'h0000_ff0b);
        // bit 0 is on, so only bit 2 may report
        open_load_cmp_in = 8'h05;
        wait_cyc(40);
        open_load_cmp_in = 8'h00;
        wait_cyc(10);
        send(16, 32'h0000_ff0b);
        check("latched", 32'h0004, {16'h0, rx[15:0]});
        send(16, 32'h0000_ff0b);
        check("cleared", 32'h0, {16'h0, rx[15:0]});
    endtask

    task automatic s_sleep;
        enable_in = 1'b0;
        wait_cyc(10);
        check("sleep", 32'h1, {31'h0, sleep_out});
        check_out(8'h00, 8'h00);
        enable_in = 1'b1;
        wait_cyc(10);
        check_out(8'h00, 8'h00);
        logic_supply_ok_in = 1'b0;
        wait_cyc(10);
        check("sleep", 32'h1, {31'h0, sleep_out});
        logic_supply_ok_in = 1'b1;
        wait_cyc(10);
    endtask

    task automatic s_uv;
        send(16, 32'h0000_0c30);
        check_out(8'h30, 8'h0c);
        battery_undervoltage_in = 1'b1;
        wait_cyc(10);
        check("drive", 32'h0, {24'h0, drive_on_out});
        battery_undervoltage_in = 1'b0;
        logic_undervoltage_in = 1'b1;
        wait_cyc(10);
        check("drive", 32'h0, {24'h0, drive_on_out});
        logic_undervoltage_in = 1'b0;
        wait_cyc(10);
        check_out(8'h00, 8'h00);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {rst_n_in, battery_overvoltage_in, battery_undervoltage_in} = 3'b000;
        {enable_in, logic_supply_ok_in, logic_undervoltage_in} = 3'b110;
        open_load_cmp_in = 8'h00;
        short_fault_in = 8'h00;
        over_temp_in = 8'h00;
        wait_cyc(3);
        rst_n_in = 1'b1;
        wait_cyc(8);
        check("sleep", 32'h0, {31'h0, sleep_out});
        check_out(8'h00, 8'h00);
        s_basic;
        s_count;
        s_echo;
        s_faults;
        s_open;
        s_sleep;
        s_uv;
        complete_run;
    end

    // nine frames with their gaps need about 2.8 ms
    initial begin
        #4_000_000;
        miscompares++;
        complete_run;
    end
endmodule
